// ---- include/i2m_pkg.sv ----
/*
 * Constants, register map and engine states of the two-wire master.
 * Assumes a 50 MHz APB clock and open-drain SDA/SCL resolved outside.
 */
// Behaviour
// - Bus tracker watches lines whenever master enabled
// - Four bus conditions readable in flags register
// - Reset or enable gives unknown; software forces idle
// - First stop moves unknown to idle
// - Enabled inactivity timeout moves unknown/busy to idle
// - Only reset or disable returns to unknown
// - Foreign start: idle to busy; stop: idle
// - Own start: owner; own stop returns idle
// - Collision while owner: busy until stop
// - Repeated start matters only if arbitration lost
// - Separate done flags plus ack, error, hold, state
// - SCL held low while a done flag set, except after loss/error
// - Divider times both SCL phases, 10+2*div
// - Target write starts; from idle waits for bus idle first, from hold gives repeated start
// - Address loss/error: flags, release lines, wait
// - Address nack: write done, ack flag high, hold
// - Write address ack: write done, ack cleared
// - Read address ack: receive byte, read done
// - Byte write clears, sends, sets write done
// - Ack flag zero means ack, one nack
// - Released SDA sampled low means arbitration lost
package i2m_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CMD  = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_DIV  = 8'h0C;
    localparam logic [7:0] A_TGT  = 8'h10;
    localparam logic [7:0] A_DATA = 8'h14;

    localparam int CTRL_EN  = 0;
    localparam int CTRL_TO  = 1;
    localparam int ST_ERR   = 2;
    localparam int ST_ARB   = 3;
    localparam int ST_ACK   = 4;
    localparam int ST_HOLD  = 5;
    localparam int ST_WDONE = 6;
    localparam int ST_RDONE = 7;

    localparam logic [1:0] CMD_RECV = 2'h2;
    localparam logic [1:0] CMD_HALT = 2'h3;

    localparam logic [1:0] BS_UNKNOWN = 2'h0;
    localparam logic [1:0] BS_IDLE    = 2'h1;
    localparam logic [1:0] BS_OWNER   = 2'h2;
    localparam logic [1:0] BS_BUSY    = 2'h3;

    localparam logic [7:0] DIV_RST    = 8'h00;
    localparam logic [8:0] PHASE_BASE = 9'h005;
    localparam logic [8:0] CNT_ONE    = 9'h001;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int BUS_TIMEOUT_NS = 50000;
    localparam logic [11:0] TO_CYCLES =
        12'(BUS_TIMEOUT_NS / CLK_PERIOD_NS);

    localparam logic [8:0] DRV_ADDR = 9'h1FE;
    localparam logic [8:0] DRV_ACK  = 9'h100;
    localparam logic [8:0] DRV_NONE = 9'h000;
    localparam logic [8:0] TX_REL   = 9'h1FF;
    localparam logic [8:0] TX_ACK   = 9'h0FF;
    localparam logic [3:0] NB_PKT   = 4'h9;
    localparam logic [3:0] NB_BYTE  = 4'h8;
    localparam logic [3:0] NB_ONE   = 4'h1;

    typedef enum logic [3:0] {
        E_IDLE, E_WAIT, E_START, E_LOW, E_HIGH, E_HOLD,
        E_RS_LOW, E_RS_HIGH, E_P_LOW, E_P_HIGH
    } i2m_eng_t;

    typedef enum logic [1:0] {K_ADDR, K_WR, K_RD, K_NACK} i2m_kind_t;
endpackage

// ---- hw/i2m_master.sv ----
/*
 * Two-wire bus master: bus condition tracker, SCL rate generation and
 * byte sequencing, registers over APB with a fixed zero-wait answer.
 * Assumes SDA/SCL inputs synchronous to pclk and open-drain resolution
 * of the *_oe outputs outside (pin low while oe is high).
 */
`timescale 1ns/1ps
`default_nettype none
module i2m_master (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);
    // Register state
    logic        en_r;
    logic        to_en_r;
    logic [7:0]  div_r;
    logic [1:0]  bs_r;
    logic [1:0]  bs_nxt;
    logic        wdone_r;
    logic        rdone_r;
    logic        arb_r;
    logic        err_r;
    logic        ack_r;
    logic        hold_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        scl_oe_r;
    logic        sda_oe_r;
    logic        lvl_r;
    // Line monitor
    logic        scl_q;
    logic        sda_q;
    logic [11:0] idle_cnt_r;
    // Engine
    i2m_pkg::i2m_eng_t  eng_r;
    i2m_pkg::i2m_eng_t  eng_nxt;
    i2m_pkg::i2m_kind_t kind_r;
    i2m_pkg::i2m_kind_t kind_nxt;
    logic [8:0]  cnt_r;
    logic [8:0]  cnt_nxt;
    logic [8:0]  tx_r;
    logic [8:0]  tx_nxt;
    logic [8:0]  drv_r;
    logic [8:0]  drv_nxt;
    logic [3:0]  nb_r;
    logic [3:0]  nb_nxt;
    logic [7:0]  rx_r;
    logic [7:0]  rx_nxt;
    logic        dir_r;
    logic        dir_nxt;
    logic        lost;
    logic        berr;
    logic        set_w;
    logic        set_r;
    logic        ack_upd;
    logic        ack_val;

    // APB decode
    wire acc     = psel & penable & pready_r;
    wire wr      = acc & pwrite;
    wire setup   = psel & ~penable & ~pready_r;
    wire hit_ctl = (paddr == i2m_pkg::A_CTRL);
    wire hit_cmd = (paddr == i2m_pkg::A_CMD);
    wire hit_st  = (paddr == i2m_pkg::A_STAT);
    wire hit_div = (paddr == i2m_pkg::A_DIV);
    wire hit_tgt = (paddr == i2m_pkg::A_TGT);
    wire hit_dat = (paddr == i2m_pkg::A_DATA);
    wire mapped  = hit_ctl | hit_cmd | hit_st | hit_div | hit_tgt
                 | hit_dat;
    wire wr_ctl  = wr & hit_ctl;
    wire wr_cmd  = wr & hit_cmd;
    wire wr_st   = wr & hit_st;
    wire wr_div  = wr & hit_div;
    wire wr_tgt  = wr & hit_tgt & en_r;
    wire wr_dat  = wr & hit_dat & en_r;
    wire [1:0] cmd_val = pwdata[1:0];

    wire [7:0] stat_val = {rdone_r, wdone_r, hold_r, ack_r, arb_r,
                           err_r, bs_r};
    wire [7:0] rd_byte =
        hit_ctl ? {6'h00, to_en_r, en_r} :
        hit_st  ? stat_val :
        hit_div ? div_r :
        hit_dat ? rx_r : 8'h00;

    // Line events, timeout
    wire start_det = scl_q & scl_in & sda_q & ~sda_in;
    wire stop_det  = scl_q & scl_in & ~sda_q & sda_in;
    wire line_chg  = (scl_in != scl_q) | (sda_in != sda_q);
    wire to_hit    = ~line_chg &
                     (idle_cnt_r == i2m_pkg::TO_CYCLES - 12'h001);
    wire [8:0] half = i2m_pkg::PHASE_BASE + {1'b0, div_r};
    wire in_hold   = (eng_r == i2m_pkg::E_HOLD);
    wire tgt_go    = wr_tgt & ((eng_r == i2m_pkg::E_IDLE) | in_hold);
    wire dat_go    = wr_dat & in_hold & ~dir_r;
    wire recv_go   = wr_cmd & in_hold & dir_r
                   & (cmd_val == i2m_pkg::CMD_RECV);
    wire halt_go   = wr_cmd & in_hold & (cmd_val == i2m_pkg::CMD_HALT);
    wire own_start = (eng_r == i2m_pkg::E_START);
    wire bit_out   = drv_r[8] & tx_r[8];
    wire cnt_end   = (cnt_r == i2m_pkg::CNT_ONE);
    wire [8:0] cnt_dec = cnt_r - i2m_pkg::CNT_ONE;
    wire in_bits   = (eng_r == i2m_pkg::E_LOW)
                   | (eng_r == i2m_pkg::E_HIGH);

    // Byte engine
    always_comb begin
        eng_nxt  = eng_r;
        cnt_nxt  = cnt_r;
        tx_nxt   = tx_r;
        drv_nxt  = drv_r;
        nb_nxt   = nb_r;
        kind_nxt = kind_r;
        rx_nxt   = rx_r;
        dir_nxt  = dir_r;
        lost     = 1'b0;
        berr     = 1'b0;
        set_w    = 1'b0;
        set_r    = 1'b0;
        ack_upd  = 1'b0;
        ack_val  = 1'b0;
        if (tgt_go) begin
            tx_nxt   = {pwdata[7:0], 1'b1};
            drv_nxt  = i2m_pkg::DRV_ADDR;
            nb_nxt   = i2m_pkg::NB_PKT;
            kind_nxt = i2m_pkg::K_ADDR;
            dir_nxt  = pwdata[0];
        end
        unique case (eng_r)
            i2m_pkg::E_IDLE: begin
                if (tgt_go) begin
                    eng_nxt = i2m_pkg::E_WAIT;
                end
            end
            i2m_pkg::E_WAIT: begin
                if (bs_r == i2m_pkg::BS_IDLE) begin
                    eng_nxt = i2m_pkg::E_START;
                    cnt_nxt = half;
                end
            end
            i2m_pkg::E_START: begin
                if (cnt_end) begin
                    eng_nxt = i2m_pkg::E_LOW;
                    cnt_nxt = half;
                end else begin
                    cnt_nxt = cnt_dec;
                end
            end
            i2m_pkg::E_LOW: begin
                if (start_det | stop_det) begin
                    berr = 1'b1;
                end else if (cnt_end) begin
                    eng_nxt = i2m_pkg::E_HIGH;
                    cnt_nxt = half;
                end else begin
                    cnt_nxt = cnt_dec;
                end
            end
            i2m_pkg::E_HIGH: begin
                if (start_det | stop_det) begin
                    berr = 1'b1;
                end else if (scl_in & bit_out & ~sda_in) begin
                    lost = 1'b1;
                end else if (scl_in & cnt_end) begin
                    rx_nxt  = {rx_r[6:0], sda_in};
                    tx_nxt  = {tx_r[7:0], 1'b1};
                    drv_nxt = {drv_r[7:0], 1'b0};
                    nb_nxt  = nb_r - i2m_pkg::NB_ONE;
                    cnt_nxt = half;
                    eng_nxt = i2m_pkg::E_LOW;
                    if (nb_r == i2m_pkg::NB_ONE) begin
                        unique case (kind_r)
                            i2m_pkg::K_ADDR: begin
                                ack_upd = 1'b1;
                                ack_val = sda_in;
                                if (sda_in | ~dir_r) begin
                                    set_w   = 1'b1;
                                    eng_nxt = i2m_pkg::E_HOLD;
                                end else begin
                                    tx_nxt   = i2m_pkg::TX_REL;
                                    drv_nxt  = i2m_pkg::DRV_NONE;
                                    nb_nxt   = i2m_pkg::NB_BYTE;
                                    kind_nxt = i2m_pkg::K_RD;
                                end
                            end
                            i2m_pkg::K_WR: begin
                                ack_upd = 1'b1;
                                ack_val = sda_in;
                                set_w   = 1'b1;
                                eng_nxt = i2m_pkg::E_HOLD;
                            end
                            i2m_pkg::K_RD: begin
                                ack_upd = 1'b1;
                                set_r   = 1'b1;
                                eng_nxt = i2m_pkg::E_HOLD;
                            end
                            i2m_pkg::K_NACK: begin
                                eng_nxt = i2m_pkg::E_P_LOW;
                            end
                        endcase
                    end
                end else if (scl_in) begin
                    cnt_nxt = cnt_dec;
                end
            end
            i2m_pkg::E_HOLD: begin
                cnt_nxt = half;
                if (tgt_go) begin
                    eng_nxt = i2m_pkg::E_RS_LOW;
                end else if (dat_go) begin
                    tx_nxt   = {pwdata[7:0], 1'b1};
                    drv_nxt  = i2m_pkg::DRV_ADDR;
                    nb_nxt   = i2m_pkg::NB_PKT;
                    kind_nxt = i2m_pkg::K_WR;
                    eng_nxt  = i2m_pkg::E_LOW;
                end else if (recv_go) begin
                    tx_nxt   = i2m_pkg::TX_ACK;
                    drv_nxt  = i2m_pkg::DRV_ACK;
                    nb_nxt   = i2m_pkg::NB_PKT;
                    kind_nxt = i2m_pkg::K_RD;
                    eng_nxt  = i2m_pkg::E_LOW;
                end else if (halt_go & dir_r) begin
                    tx_nxt   = i2m_pkg::TX_REL;
                    drv_nxt  = i2m_pkg::DRV_ACK;
                    nb_nxt   = i2m_pkg::NB_ONE;
                    kind_nxt = i2m_pkg::K_NACK;
                    eng_nxt  = i2m_pkg::E_LOW;
                end else if (halt_go) begin
                    eng_nxt = i2m_pkg::E_P_LOW;
                end
            end
            i2m_pkg::E_RS_LOW: begin
                if (cnt_end) begin
                    eng_nxt = i2m_pkg::E_RS_HIGH;
                    cnt_nxt = half;
                end else begin
                    cnt_nxt = cnt_dec;
                end
            end
            i2m_pkg::E_RS_HIGH: begin
                if (scl_in & ~sda_in) begin
                    lost = 1'b1;
                end else if (scl_in & cnt_end) begin
                    eng_nxt = i2m_pkg::E_START;
                    cnt_nxt = half;
                end else if (scl_in) begin
                    cnt_nxt = cnt_dec;
                end
            end
            i2m_pkg::E_P_LOW: begin
                if (cnt_end) begin
                    eng_nxt = i2m_pkg::E_P_HIGH;
                    cnt_nxt = half;
                end else begin
                    cnt_nxt = cnt_dec;
                end
            end
            i2m_pkg::E_P_HIGH: begin
                if (scl_in & cnt_end) begin
                    eng_nxt = i2m_pkg::E_IDLE;
                end else if (scl_in) begin
                    cnt_nxt = cnt_dec;
                end
            end
        endcase
        if (lost | berr) begin
            set_w   = 1'b1;
            eng_nxt = i2m_pkg::E_IDLE;
        end
        if (!en_r) begin
            eng_nxt = i2m_pkg::E_IDLE;
        end
    end

    // Flags: hardware set wins over software clear
    wire clr_cmd = tgt_go | dat_go | recv_go | halt_go;
    wire clr_w   = (wr_st & pwdata[i2m_pkg::ST_WDONE]) | clr_cmd;
    wire clr_r   = (wr_st & pwdata[i2m_pkg::ST_RDONE]) | clr_cmd;
    wire clr_a   = (wr_st & pwdata[i2m_pkg::ST_ARB]) | tgt_go;
    wire clr_e   = (wr_st & pwdata[i2m_pkg::ST_ERR]) | tgt_go;
    wire wdone_nxt = (wdone_r & ~clr_w) | set_w;
    wire rdone_nxt = (rdone_r & ~clr_r) | set_r;
    wire arb_nxt   = (arb_r & ~clr_a) | lost | berr;
    wire err_nxt   = (err_r & ~clr_e) | berr;
    wire ack_nxt   = ack_upd ? ack_val : ack_r;
    wire hold_nxt  = (eng_nxt == i2m_pkg::E_HOLD)
                   & (wdone_nxt | rdone_nxt);

    // Pin drive from the next engine state
    wire bits_nxt = (eng_nxt == i2m_pkg::E_LOW)
                  | (eng_nxt == i2m_pkg::E_HIGH);
    wire scl_drv  = (eng_nxt == i2m_pkg::E_LOW)
                  | (eng_nxt == i2m_pkg::E_RS_LOW)
                  | (eng_nxt == i2m_pkg::E_P_LOW) | hold_nxt;
    wire sda_drv  = (bits_nxt & drv_nxt[8] & ~tx_nxt[8])
                  | (eng_nxt == i2m_pkg::E_START)
                  | (eng_nxt == i2m_pkg::E_P_LOW)
                  | (eng_nxt == i2m_pkg::E_P_HIGH);

    // Bus condition tracker
    always_comb begin
        bs_nxt = bs_r;
        if (!en_r) begin
            bs_nxt = i2m_pkg::BS_UNKNOWN;
        end else if (lost | berr) begin
            bs_nxt = i2m_pkg::BS_BUSY;
        end else if (stop_det) begin
            bs_nxt = i2m_pkg::BS_IDLE;
        end else if (start_det & own_start) begin
            if ((bs_r == i2m_pkg::BS_IDLE) | (bs_r == i2m_pkg::BS_OWNER)) begin
                bs_nxt = i2m_pkg::BS_OWNER;
            end
        end else if (start_det & (bs_r == i2m_pkg::BS_IDLE)) begin
            bs_nxt = i2m_pkg::BS_BUSY;
        end else if (to_hit & to_en_r & ((bs_r == i2m_pkg::BS_UNKNOWN)
                     | (bs_r == i2m_pkg::BS_BUSY))) begin
            bs_nxt = i2m_pkg::BS_IDLE;
        end else if (wr_st & (pwdata[1:0] == i2m_pkg::BS_IDLE)) begin
            bs_nxt = i2m_pkg::BS_IDLE;
        end
    end

    // APB slave: data set up in the setup cycle, pready one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            pready_r  <= setup;
            prdata_r  <= setup ? {24'h00_0000, rd_byte} : prdata_r;
            pslverr_r <= setup & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r    <= 1'b0;
            to_en_r <= 1'b0;
            div_r   <= i2m_pkg::DIV_RST;
        end else if (ce) begin
            en_r    <= wr_ctl ? pwdata[i2m_pkg::CTRL_EN] : en_r;
            to_en_r <= wr_ctl ? pwdata[i2m_pkg::CTRL_TO] : to_en_r;
            div_r   <= wr_div ? pwdata[7:0] : div_r;
        end
    end

    // Line monitor runs whenever the master is enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            idle_cnt_r <= 12'h000;
        end else if (ce) begin
            scl_q      <= scl_in;
            sda_q      <= sda_in;
            if (line_chg | !en_r | to_hit) begin
                idle_cnt_r <= 12'h000;
            end else begin
                idle_cnt_r <= idle_cnt_r + 12'h001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bs_r    <= i2m_pkg::BS_UNKNOWN;
            wdone_r <= 1'b0;
            rdone_r <= 1'b0;
            arb_r   <= 1'b0;
            err_r   <= 1'b0;
            ack_r   <= 1'b0;
            hold_r  <= 1'b0;
        end else if (ce) begin
            bs_r    <= bs_nxt;
            wdone_r <= wdone_nxt;
            rdone_r <= rdone_nxt;
            arb_r   <= arb_nxt;
            err_r   <= err_nxt;
            ack_r   <= ack_nxt;
            hold_r  <= hold_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_r  <= i2m_pkg::E_IDLE;
            kind_r <= i2m_pkg::K_ADDR;
            cnt_r  <= 9'h000;
            tx_r   <= 9'h000;
            drv_r  <= 9'h000;
            nb_r   <= 4'h0;
            rx_r   <= 8'h00;
            dir_r  <= 1'b0;
        end else if (ce) begin
            eng_r  <= eng_nxt;
            kind_r <= kind_nxt;
            cnt_r  <= cnt_nxt;
            tx_r   <= tx_nxt;
            drv_r  <= drv_nxt;
            nb_r   <= nb_nxt;
            rx_r   <= rx_nxt;
            dir_r  <= dir_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            lvl_r    <= 1'b0;
        end else if (ce) begin
            scl_oe_r <= scl_drv;
            sda_oe_r <= sda_drv;
            lvl_r    <= 1'b0;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign scl_oe  = scl_oe_r;
    assign sda_oe  = sda_oe_r;
    assign scl_out = lvl_r;
    assign sda_out = lvl_r;
endmodule
`default_nettype wire

// ---- verification/i2m_master_assertions.sv ----
/* Port checker for the two-wire master.
   Assumes one APB answer cycle after each setup cycle. */
`timescale 1ns/1ps
`default_nettype none
module i2m_master_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_out,
    input wire logic        sda_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_ready_setup: assert property (ce && psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_phase: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_unmapped: assert property (psel && !penable && paddr > 8'h14
        |=> pslverr) else $error("unmapped access not refused");
    a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused access returned data");
    a_data_width: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_drive_low: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    a_freeze_lines: assert property (!ce |=> $stable({scl_oe, sda_oe}))
        else $error("lines moved while clock disabled");
    a_disable_free: assert property (psel && penable && pready
        && pwrite && paddr == i2m_pkg::A_CTRL
        && !pwdata[i2m_pkg::CTRL_EN]
        |-> ##[1:2] !scl_oe && !sda_oe) else $error("lines held after off");
endmodule
bind i2m_master i2m_master_assertions i2m_master_assertions_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe));
`default_nettype wire

// ---- verification/i2m_slave_model.sv ----
/* Behavioural bus slave: acks its address, takes written bytes,
   sends one fixed byte on reads. Assumes pulled-up wire levels. */
`timescale 1ns/1ps
`default_nettype none
module i2m_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A,
    parameter logic [7:0] RDAT = 8'hC5
) (
    input  wire logic       clk,
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            pull,
    output logic [7:0]      got
);
    logic       scl_q, sda_q, act, adr, rd;
    logic [3:0] bit_n;
    logic [7:0] sh, tx;
    initial {pull, act, rd, adr, scl_q, sda_q, got} = 14'h0C00;
    always @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda_q && !sda) begin
            {act, adr, rd, pull, bit_n} <= 8'hC0;
        end else if (scl && scl_q && !sda_q && sda) begin
            {act, pull} <= 2'b00;
        end else if (act && scl && !scl_q) begin
            sh <= {sh[6:0], sda};
            bit_n <= bit_n + 4'h1;
            if (bit_n == 4'h8 && rd && !adr && sda) act <= 1'b0;
        end else if (act && !scl && scl_q) begin
            tx <= {tx[6:0], 1'b0};
            pull <= rd && !adr && !tx[7] && bit_n != 4'h8;
            if (bit_n == 4'h9) begin
                bit_n <= 4'h0;
                adr <= 1'b0;
                tx <= {RDAT[6:0], 1'b0};
                pull <= rd && !RDAT[7];
            end else if (bit_n == 4'h8 && (adr || !rd)) begin
                pull <= !adr || sh[7:1] == ADDR;
                act <= !adr || sh[7:1] == ADDR;
                if (adr) rd <= sh[0];
                else got <= sh;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb_i2m_master.sv ----
/* Bench for i2m_master: APB tasks, slave model and an SDA pull-down (tb_sda) for foreign bus events.
   Assumes the package map and pulled-up open-drain lines. */
`timescale 1ns/1ps
`default_nettype none
module tb_i2m_master;
    localparam logic [7:0] DIV = 8'h03;
    logic        pclk, presetn, ce, psel, penable, pwrite, tb_sda, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd, n;
    int          error_cnt, compares, cyc;
    wire logic [31:0] prdata;
    wire logic   pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, pull;
    wire logic [7:0]  got;
    wire logic   scl_w = !scl_oe;
    wire logic   sda_w = !(sda_oe || pull || tb_sda);
    i2m_master i2m_master_i (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
    i2m_slave_model i2m_slave_model_i (.clk(pclk), .scl(scl_w),
        .sda(sda_w), .pull(pull), .got(got));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task results;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            error_cnt++;
            results();
        end
    end
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %0h not %0h", $time, g, e);
        end
    endtask
    task wst(input logic [7:0] m, input logic [7:0] v, input logic [7:0] e);
        do apb(1'b0, i2m_pkg::A_STAT, 32'h0); while ((rd[7:0] & m) !== v);
        chk(rd, {24'h0, e});
    endtask
    task bus(input logic p);
        @(posedge pclk);
        tb_sda <= p;
        repeat (4) @(posedge pclk);
    endtask
    initial begin
        {presetn, ce, psel, penable, pwrite, tb_sda} = 6'b010000;
        {paddr, pwdata, error_cnt, compares, cyc} = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wst(8'h00, 8'h00, 8'h00);
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
        apb(1'b1, i2m_pkg::A_DIV, {24'h0, DIV});
        apb(1'b1, i2m_pkg::A_CTRL, 32'h1);
        wst(8'h00, 8'h00, 8'h00);
        bus(1'b1);
        bus(1'b0);
        wst(8'h00, 8'h00, 8'h01);
        bus(1'b1);
        wst(8'h00, 8'h00, 8'h03);
        bus(1'b0);
        wst(8'h00, 8'h00, 8'h01);
        $display("test tracker ended");
        apb(1'b1, i2m_pkg::A_TGT, 32'h54);
        wst(8'h40, 8'h40, 8'h62);
        chk({31'h0, scl_w}, 32'h0);
        apb(1'b1, i2m_pkg::A_DATA, 32'hA6);
        while (scl_oe !== 1'b0) @(posedge pclk);
        while (scl_oe !== 1'b1) @(posedge pclk);
        for (n = 0; scl_oe === 1'b1; n++) @(posedge pclk);
        chk(n, 32'h5 + {24'h0, DIV});
        wst(8'h40, 8'h40, 8'h62);
        chk({24'h0, got}, 32'hA6);
        apb(1'b1, i2m_pkg::A_TGT, 32'h54);
        wst(8'h40, 8'h40, 8'h62);
        apb(1'b1, i2m_pkg::A_CMD, 32'(i2m_pkg::CMD_HALT));
        wst(8'h03, 8'h01, 8'h01);
        apb(1'b1, i2m_pkg::A_TGT, 32'h2A);
        wst(8'h40, 8'h40, 8'h72);
        apb(1'b1, i2m_pkg::A_CMD, 32'(i2m_pkg::CMD_HALT));
        wst(8'h03, 8'h01, 8'h11);
        apb(1'b1, i2m_pkg::A_TGT, 32'h55);
        wst(8'h80, 8'h80, 8'hA2);
        apb(1'b0, i2m_pkg::A_DATA, 32'h0);
        chk(rd, 32'hC5);
        apb(1'b1, i2m_pkg::A_CMD, 32'(i2m_pkg::CMD_RECV));
        wst(8'h80, 8'h80, 8'hA2);
        apb(1'b0, i2m_pkg::A_DATA, 32'h0);
        chk(rd, 32'hC5);
        apb(1'b1, i2m_pkg::A_CMD, 32'(i2m_pkg::CMD_HALT));
        wst(8'h03, 8'h01, 8'h01);
        $display("test transfers ended");
        apb(1'b1, i2m_pkg::A_TGT, 32'hA0);
        while (scl_oe !== 1'b1) @(posedge pclk);
        tb_sda <= 1'b1;
        wst(8'h40, 8'h40, 8'h4B);
        chk({30'h0, scl_oe, sda_oe}, 32'h0);
        bus(1'b0);
        wst(8'h03, 8'h01, 8'h49);
        apb(1'b1, i2m_pkg::A_STAT, 32'h49);
        wst(8'h00, 8'h00, 8'h01);
        $display("test arbitration ended");
        apb(1'b1, i2m_pkg::A_CTRL, 32'h3);
        bus(1'b1);
        wst(8'h00, 8'h00, 8'h03);
        repeat (2600) @(posedge pclk);
        wst(8'h00, 8'h00, 8'h01);
        bus(1'b0);
        apb(1'b1, i2m_pkg::A_CTRL, 32'h0);
        wst(8'h00, 8'h00, 8'h00);
        apb(1'b1, i2m_pkg::A_CTRL, 32'h1);
        apb(1'b1, i2m_pkg::A_STAT, 32'h1);
        wst(8'h00, 8'h00, 8'h01);
        apb(1'b0, 8'h20, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("test control ended");
        results();
    end
endmodule
`default_nettype wire
